// >>> design/tmr_fifo.sv
// Parameterised valid/ready FIFO for parallel characters.
`timescale 1ns/1ps
`default_nettype none
module tmr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Full and empty follow the occupancy count.
  assign in_ready = (cnt_q < (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];

  // Storage writes.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// >>> design/tmr_pkg.sv
// Package with constants and types for the test message ROM sequencer.
// Overview of operation
// - ROM is read one character at a time by a six-bit count up to 63.
// - ASCII uses all eight ROM lines; baudot uses only the first five.
// - Station identifier and TEST come from switches, not from the ROM.
// - The ROM counter is six-bit binary and advances only while phase select is high.
// - Phase select low runs the programmed-character counter; only one counter runs.
// - Phase select levels clear the ROM counter to zero at each new message.
// - With phase select high and step enable set, each data-enter strobe that the FIFO can accept steps the ROM counter by one.
// - Step enable only for test-message or 5-level and 8-level programmed settings.
// - First four ROM characters are CR/LF; the line-end insert plays those then resets.
// - Each counter step gives a ROM read strobe loading the character in parallel.
// - Format is 0 (ASCII) for 8-level settings, 1 (baudot) otherwise.
// - Full count on all six stages resets the phase flip-flop at message end.
// - Count 4 resets the phase flip-flop in 5/8-level settings when line-end enabled.
// - Output gate passes the last register stage, or Mark when output is disallowed.
// - Gate always enabled except programmed characters, inhibited after the set length.
// - The signal indicator is on for Mark and off for Space.
// - A per-six-character counter reaching twelve triggers the line-end insert.
// - In 6-level or 7-level programmed settings the phase flip-flop is held set.
package tmr_pkg;

  localparam int TMR_ADDR_W = 6;
  localparam int TMR_CHAR_W = 8;
  localparam int TMR_BAUDOT_W = 5;
  localparam logic [5:0] TMR_FULL_COUNT = 6'h3F;
  localparam logic [5:0] TMR_CRLF_END = 6'h04;
  localparam logic [3:0] TMR_LINE_GROUPS = 4'hC;
  localparam logic [3:0] TMR_PROG_LEN = 4'h6;
  localparam logic [3:0] TMR_FOX_LEN = 4'hC;
  localparam logic TMR_PHASE_RESET = 1'b1;
  localparam int TMR_FIFO_DEPTH = 16;

  // Settings of the pattern selector that this block cares about.
  typedef enum logic [2:0] {
    TMR_PAT_OTHER,
    TMR_PAT_FOX5,
    TMR_PAT_FOX8,
    TMR_PAT_SEL5,
    TMR_PAT_SEL6,
    TMR_PAT_SEL7,
    TMR_PAT_SEL8
  } tmr_pattern_type;

  // A parallel character on its way to the data register.
  typedef struct packed {
    logic from_rom;
    logic baudot;
    logic [7:0] bits;
  } tmr_char_type;

endpackage

// >>> design/tmr_sequencer.sv
// Test message ROM sequencer with phase control and output gate.
`timescale 1ns/1ps
`default_nettype none
module tmr_sequencer
  import tmr_pkg::*;
#(
  parameter int DEPTH = TMR_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Front and rear panel settings, already synchronous.
  input wire tmr_pattern_type pattern,
  input wire logic line_end_enable,
  input wire logic [2:0] seq_length,
  input wire logic [7:0] prog_char [6],
  input wire logic [7:0] station_id [6],
  input wire logic [7:0] test_word [6],
  // Character timing strobes.
  input wire logic data_enter,
  input wire logic last_stage_bit,
  input wire logic char_boundary,
  // Character ROM port.
  output logic [5:0] rom_addr,
  output logic rom_read,
  output logic rom_format,
  input wire logic [7:0] rom_data,
  // Parallel load towards the data register.
  output logic load_valid,
  input wire logic load_ready,
  output tmr_char_type load_char,
  // Line output.
  output logic gated_out,
  output logic signal_lamp,
  output logic message_phase_select,
  output logic char_output_allow
);
  logic [5:0] rom_cnt_q;
  logic [3:0] sel_cnt_q;
  logic [3:0] line_cnt_q;
  logic phase_q;
  logic allow_q;
  logic out_q;
  logic rd_q;
  logic step_enable;
  logic is_fox;
  logic is_sel58;
  logic held_set;
  logic fmt;
  logic insert_q;
  logic strobe;
  logic fifo_in_ready;
  logic six_char_cycle_pulse;
  tmr_char_type rom_char;
  tmr_char_type sel_char;
  tmr_char_type push_char;
  logic push_valid;
  logic full_hit;
  logic crlf_hit;
  logic line_hit;

  // Pattern decoding for the enables.
  assign is_fox = (pattern == TMR_PAT_FOX5) || (pattern == TMR_PAT_FOX8);
  assign is_sel58 = (pattern == TMR_PAT_SEL5) || (pattern == TMR_PAT_SEL8);
  assign held_set = (pattern == TMR_PAT_SEL6) || (pattern == TMR_PAT_SEL7);
  assign step_enable = is_fox || is_sel58;
  assign fmt = !((pattern == TMR_PAT_SEL8) || (pattern == TMR_PAT_FOX8));
  assign rom_format = fmt;
  // Back-pressure from the FIFO stalls every step.
  assign strobe = data_enter && fifo_in_ready;

  // ROM character taken whole or trimmed to five bits.
  always_comb begin
    rom_char.from_rom = 1'b1;
    rom_char.baudot = fmt;
    rom_char.bits = fmt ? {3'h0, rom_data[4:0]} : rom_data;
  end

  // Programmed character or message ending from switches.
  always_comb begin
    sel_char.from_rom = 1'b0;
    sel_char.baudot = fmt;
    sel_char.bits = 8'h00;
    if (is_fox) begin
      if (sel_cnt_q < 4'h6) begin
        sel_char.bits = station_id[sel_cnt_q[2:0]];
      end else begin
        sel_char.bits = test_word[3'(sel_cnt_q - 4'h6)];
      end
    end else if (sel_cnt_q < 4'h6) begin
      sel_char.bits = prog_char[sel_cnt_q[2:0]];
    end
    if (fmt) begin
      sel_char.bits[7:5] = 3'h0;
    end
  end

  // Detectors that end or start a ROM phase.
  assign full_hit = (rom_cnt_q == TMR_FULL_COUNT);
  assign crlf_hit = is_sel58 && line_end_enable && insert_q
                    && (rom_cnt_q == TMR_CRLF_END - 6'h01);
  assign six_char_cycle_pulse = strobe && !phase_q && is_sel58
                                && (sel_cnt_q == TMR_PROG_LEN - 4'h1);
  assign line_hit = six_char_cycle_pulse && line_end_enable
                    && (line_cnt_q == TMR_LINE_GROUPS - 4'h1);

  // ROM address counter steps only in the ROM phase.
  always_ff @(posedge clk) begin
    if (reset) begin
      rom_cnt_q <= '0;
    end else if (!phase_q || held_set) begin
      rom_cnt_q <= '0;
    end else if (strobe && step_enable) begin
      rom_cnt_q <= rom_cnt_q + 6'h01;
    end
  end

  // Programmed-character counter runs while phase is low, and in 6/7-level settings.
  always_ff @(posedge clk) begin
    if (reset) begin
      sel_cnt_q <= '0;
    end else if (phase_q && !held_set) begin
      sel_cnt_q <= '0;
    end else if (strobe) begin
      if (held_set || is_sel58) begin
        sel_cnt_q <= (sel_cnt_q == TMR_PROG_LEN - 4'h1) ? '0 : sel_cnt_q + 4'h1;
      end else begin
        sel_cnt_q <= (sel_cnt_q == TMR_FOX_LEN - 4'h1) ? '0 : sel_cnt_q + 4'h1;
      end
    end
  end

  // Seventy-two character counter, stepped every six characters.
  always_ff @(posedge clk) begin
    if (reset || !is_sel58) begin
      line_cnt_q <= '0;
    end else if (six_char_cycle_pulse) begin
      line_cnt_q <= line_hit ? '0 : line_cnt_q + 4'h1;
    end
  end

  // Message-phase flip-flop: high selects the ROM counter.
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_q <= TMR_PHASE_RESET;
      insert_q <= 1'b0;
    end else if (held_set) begin
      phase_q <= 1'b1;
      insert_q <= 1'b0;
    end else if (!step_enable) begin
      phase_q <= 1'b0;
      insert_q <= 1'b0;
    end else if (strobe) begin
      if (phase_q && is_sel58 && !insert_q) begin
        phase_q <= 1'b0;
      end else if (phase_q && (full_hit || crlf_hit)) begin
        phase_q <= 1'b0;
        insert_q <= 1'b0;
      end else if (!phase_q && is_fox && sel_cnt_q == TMR_FOX_LEN - 4'h1) begin
        phase_q <= 1'b1;
      end else if (line_hit) begin
        phase_q <= 1'b1;
        insert_q <= 1'b1;
      end
    end
  end

  // ROM read strobe accompanies each step.
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= strobe && phase_q && step_enable && !held_set;
    end
  end
  assign rom_read = rd_q;
  assign rom_addr = rom_cnt_q;

  // Character pushed toward the data register.
  assign push_valid = strobe && (phase_q && step_enable && !held_set
                      || !phase_q || held_set);
  assign push_char = (phase_q && !held_set) ? rom_char : sel_char;

  tmr_fifo #(.WIDTH($bits(tmr_char_type)), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_char),
    .out_valid(load_valid),
    .out_ready(load_ready),
    .out_data(load_char)
  );

  // Output allow flip-flop, cleared once the chosen length is sent.
  always_ff @(posedge clk) begin
    if (reset) begin
      allow_q <= 1'b1;
    end else if (!(is_sel58 || held_set)) begin
      allow_q <= 1'b1;
    end else if (char_boundary && sel_cnt_q == 4'h0) begin
      allow_q <= 1'b1;
    end else if (char_boundary && sel_cnt_q >= {1'b0, seq_length}) begin
      allow_q <= 1'b0;
    end
  end

  // Output gate forcing Mark when output is disallowed.
  always_ff @(posedge clk) begin
    if (reset) begin
      out_q <= 1'b1;
    end else begin
      out_q <= allow_q ? last_stage_bit : 1'b1;
    end
  end

  assign gated_out = out_q;
  assign signal_lamp = out_q;
  assign message_phase_select = phase_q;
  assign char_output_allow = allow_q;

  AST_STEP: assert property (@(posedge clk) disable iff (reset)
    strobe && phase_q && step_enable && !held_set && rom_cnt_q != 6'h3F
    |=> rom_cnt_q == $past(rom_cnt_q) + 6'h01) else $error("ROM counter did not step.");
  AST_HOLD: assert property (@(posedge clk) disable iff (reset)
    !phase_q |=> rom_cnt_q == 6'h00) else $error("ROM counter not cleared.");
  AST_FMT: assert property (@(posedge clk) disable iff (reset)
    pattern == TMR_PAT_FOX8 |-> !rom_format) else $error("Wrong format level.");
  AST_MARK: assert property (@(posedge clk) disable iff (reset)
    !allow_q |=> gated_out) else $error("Mark not forced.");
  AST_LAMP: assert property (@(posedge clk) disable iff (reset)
    signal_lamp == gated_out) else $error("Lamp disagrees with output.");
  AST_SET67: assert property (@(posedge clk) disable iff (reset)
    held_set |=> phase_q) else $error("Phase not held set.");
  AST_FULL: assert property (@(posedge clk) disable iff (reset)
    strobe && phase_q && full_hit && !held_set && step_enable |=> !phase_q)
    else $error("Full count did not end phase.");
  AST_READ: assert property (@(posedge clk) disable iff (reset)
    rom_read |-> $past(phase_q)) else $error("Read outside ROM phase.");
  AST_ALLOW: assert property (@(posedge clk) disable iff (reset)
    is_fox ##1 is_fox |-> allow_q) else $error("Gate inhibited outside programmed.");
  COV_FOX_END: cover property (@(posedge clk) is_fox && full_hit && strobe);
  COV_INSERT: cover property (@(posedge clk) line_hit);
  COV_CRLF: cover property (@(posedge clk) crlf_hit && strobe);
endmodule
`default_nettype wire

// >>> sim/test_tmr_sequencer.sv
// Self-checking bench for the test message ROM sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module test_tmr_sequencer
  import tmr_pkg::*;
;
  logic clk = 0, reset = 1, line_end_enable = 0, data_enter = 0, char_boundary = 0;
  logic last_stage_bit = 1, load_ready = 0;
  tmr_pattern_type pattern = TMR_PAT_FOX8;
  logic [2:0] seq_length = 3'h6;
  logic [7:0] prog_char [6], station_id [6], test_word [6];
  logic [5:0] rom_addr, held;
  logic [7:0] rom_data;
  logic rom_read, rom_format, load_valid, gated_out, signal_lamp, message_phase_select;
  logic char_output_allow;
  tmr_char_type load_char;
  logic [15:0] lamp_errs, space_cycles;
  int err_total = 0, n_compared = 0, seed = 32'h21c601f4, pops, i;
  tmr_pattern_type quiet [3] = '{TMR_PAT_SEL6, TMR_PAT_SEL7, TMR_PAT_OTHER};

  // Bench ROM contents: an address-dependent pattern that differs in every byte.
  function automatic logic [7:0] rom_fn(input logic [5:0] a);
    return {a, 2'h1} ^ 8'hA5;
  endfunction
  assign rom_data = rom_fn(rom_addr);

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  tmr_sequencer #(.DEPTH(16)) i_dut (.clk(clk), .reset(reset), .pattern(pattern),
    .line_end_enable(line_end_enable), .seq_length(seq_length), .prog_char(prog_char),
    .station_id(station_id), .test_word(test_word), .data_enter(data_enter),
    .last_stage_bit(last_stage_bit), .char_boundary(char_boundary), .rom_addr(rom_addr),
    .rom_read(rom_read), .rom_format(rom_format), .rom_data(rom_data),
    .load_valid(load_valid), .load_ready(load_ready), .load_char(load_char),
    .gated_out(gated_out), .signal_lamp(signal_lamp),
    .message_phase_select(message_phase_select), .char_output_allow(char_output_allow));

  tmr_loop_model i_loop (.clk(clk), .reset(reset), .line(gated_out), .lamp(signal_lamp),
    .lamp_errs(lamp_errs), .space_cycles(space_cycles));

  // Print the counts and the verdict, then stop.
  task finish_test;
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task done(input string s);
    $display("test %s done", s);
  endtask

  // Hold reset for eight cycles with the given pattern selected.
  task rst(input tmr_pattern_type p);
    pattern = p;
    reset = 1;
    repeat (8) @(negedge clk);
    reset = 0;
    @(negedge clk);
  endtask

  // Spaced data-enter strobes, each followed by a character boundary pulse.
  task strobe(input int n);
    for (int k = 0; k < n; k++) begin
      data_enter = 1;
      @(negedge clk);
      data_enter = 0;
      char_boundary = 1;
      @(negedge clk);
      char_boundary = 0;
    end
  endtask

  // A hang ends the run as a failure.
  initial begin
    #200000;
    err_total++;
    finish_test;
  end

  initial begin
    for (i = 0; i < 6; i++) begin
      prog_char[i] = 8'($random(seed));
      station_id[i] = 8'($random(seed));
      test_word[i] = 8'($random(seed));
    end
    rst(TMR_PAT_FOX8);
    `CHK(rom_addr, 6'h00)
    `CHK({message_phase_select, char_output_allow, gated_out, rom_read, load_valid}, 5'h1C)
    done("reset");
    // Back-to-back strobes into a stalled FIFO: only sixteen are taken.
    data_enter = 1;
    repeat (20) @(negedge clk);
    data_enter = 0;
    @(negedge clk);
    `CHK(rom_addr, 6'h10)
    `CHK(load_valid, 1'b1)
    done("fill");
    // Drain with random stalls; characters come out in address order, all eight bits.
    pops = 0;
    for (i = 0; i < 400 && pops < 16; i++) begin
      load_ready = (($random(seed) & 1) == 1);
      // The word that stands now is the one taken at the coming rising edge.
      if (load_valid === 1'b1 && load_ready === 1'b1) begin
        `CHK(load_char, {2'b10, rom_fn(pops[5:0])})
        pops++;
      end
      @(negedge clk);
    end
    `CHK(pops, 16)
    load_ready = 1;
    @(negedge clk);
    `CHK(load_valid, 1'b0)
    done("drain");
    // One strobe gives one step and one read pulse, then run to full count.
    data_enter = 1;
    @(negedge clk);
    data_enter = 0;
    `CHK({rom_addr, rom_read}, {6'h11, 1'b1})
    @(negedge clk);
    `CHK(rom_read, 1'b0)
    strobe(46);
    `CHK({rom_addr, message_phase_select}, {6'h3F, 1'b1})
    strobe(1);
    `CHK(message_phase_select, 1'b0)
    held = rom_addr;
    // Message ending: six station characters, then the test word, from the switches.
    for (i = 0; i < 12; i++) begin
      data_enter = 1;
      @(negedge clk);
      data_enter = 0;
      `CHK(load_char, {2'b00, (i < 6) ? station_id[i] : test_word[i - 6]})
      `CHK(rom_addr, held)
      @(negedge clk);
    end
    `CHK({rom_addr, message_phase_select}, {held, 1'b1})
    done("full count");
    // Baudot message keeps only the low five ROM lines.
    load_ready = 0;
    rst(TMR_PAT_FOX5);
    strobe(1);
    `CHK(load_valid, 1'b1)
    `CHK(load_char, {2'b11, rom_fn(6'h00) & 8'h1F})
    done("baudot");
    // Patterns without a ROM step enable never move the counter.
    load_ready = 1;
    for (int q = 0; q < 3; q++) begin
      rst(quiet[q]);
      strobe(4);
      `CHK(rom_addr, 6'h00)
      if (q < 2) `CHK(message_phase_select, 1'b1)
    end
    done("no step");
    // ROM format select for every pattern setting.
    for (int p = 0; p < 7; p++) begin
      pattern = tmr_pattern_type'(p);
      @(negedge clk);
      `CHK(rom_format, !(p == 2 || p == 6))
    end
    done("format");
    // Output gate follows the last register stage outside programmed characters.
    rst(TMR_PAT_FOX8);
    for (i = 0; i < 30; i++) begin
      last_stage_bit = (($random(seed) & 1) == 1);
      @(negedge clk);
      `CHK({gated_out, char_output_allow}, {last_stage_bit, 1'b1})
    end
    `CHK(lamp_errs, 16'h0000)
    `CHK(space_cycles != 16'h0000, 1'b1)
    done("gate");
    // Programmed 8-level characters: gate inhibit after the set length, then line-end insert.
    load_ready = 1;
    line_end_enable = 1;
    seq_length = 3'(($unsigned($random(seed)) % 5) + 1);
    rst(TMR_PAT_SEL8);
    strobe(1);
    `CHK({message_phase_select, char_output_allow}, 2'b01)
    strobe(seq_length - 1);
    `CHK(char_output_allow, 1'b1)
    strobe(1);
    `CHK(char_output_allow, 1'b0)
    last_stage_bit = 0;
    @(negedge clk);
    `CHK(gated_out, 1'b1)
    strobe(6 - seq_length);
    `CHK(char_output_allow, 1'b1)
    strobe(66);
    `CHK({message_phase_select, rom_addr}, {1'b1, 6'h00})
    strobe(3);
    `CHK({message_phase_select, rom_addr}, {1'b1, 6'h03})
    strobe(1);
    `CHK({message_phase_select, rom_addr}, {1'b0, 6'h00})
    done("line end");
    finish_test;
  end
endmodule
`default_nettype wire

// >>> sim/tmr_loop_model.sv
// Behavioural teleprinter loop that watches the gated line and the panel lamp.
`timescale 1ns/1ps
`default_nettype none
module tmr_loop_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Loop line and panel lamp.
  input wire logic line,
  input wire logic lamp,
  // Tallies seen on the loop.
  output logic [15:0] lamp_errs,
  output logic [15:0] space_cycles
);
  // Count lamp disagreements and cycles in which the loop sees a Space.
  always_ff @(posedge clk) begin
    if (reset) begin
      lamp_errs <= 16'h0000;
      space_cycles <= 16'h0000;
    end else begin
      if (lamp !== line) lamp_errs <= lamp_errs + 16'h0001;
      if (line === 1'b0) space_cycles <= space_cycles + 16'h0001;
    end
  end
endmodule
`default_nettype wire
